// ---- src/buck3_consts.vh ----
// constants for the third buck converter configuration bank
`ifndef BUCK3_CONSTS_VH
`define BUCK3_CONSTS_VH
// register offsets, printed offsets are not word multiples so these are indices
`define CONTROL_TWO_IDX 16'h4061
`define ON_CONFIG_IDX 16'h4062
`define SLEEP_CONTROL_IDX 16'h4063
// control two fields
`define HWSRC_HI 12
`define HWSRC_LO 11
`define HWVSEL_BIT 10
`define HWMODE_HI 9
`define HWMODE_LO 8
`define OVP_BIT 7
// on config fields
`define SLOT_HI 15
`define SLOT_LO 13
`define ONMODE_HI 9
`define ONMODE_LO 8
`define VUP_HI 6
`define VUP_LO 2
`define VLO_HI 1
`define VLO_LO 0
// sleep code field
`define SLPV_HI 6
`define SLPV_LO 0
// reset values
`define HWSRC_RST 2'h0
`define HWVSEL_RST 1'h0
`define HWMODE_RST 2'h3
`define OVP_RST 1'h0
`define SLOT_RST 3'h0
`define ONMODE_RST 2'h1
`define VUP_RST 5'h00
`define VLO_RST 2'h0
`define SLPV_RST 7'h00
// codes
`define MODE_FCCM 2'h0
`define MODE_AUTO 2'h1
`define MODE_OFF 2'h1
`define MODE_LDO 2'h2
`define MODE_HYST 2'h3
`define SRC_NONE 2'h0
`define SRC_IN1 2'h1
`define SRC_IN2 2'h2
`define SRC_EITHER 2'h3
`define SLOT_NEVER 3'h0
`define SLOT_LAST 3'h5
`define SLOT_HWEN1 3'h6
`define SLOT_HWEN2 3'h7
`define VCODE_SAT 7'h66
`define VCODE_MAX_STEP 7'h66
// millivolts
`define MV_BASE 12'h352
`define MV_STEP 12'h019
`define MV_SAT 12'hd48
`endif

// ---- src/buck3_hw_ctrl_on_config.v ----
// third buck converter hardware-control and on-state configuration bank
//
// Overview of operation
// - under hardware control voltage is on code when select 0, sleep code when 1
// - hardware-control mode: 00 fccm, 01 converter off, 10 ldo, 11 hysteretic
// - on slot 000 never enables; 001..101 enable in timeslots 1..5
// - on slot 110 hands enable to hw enable 1, 111 to hw enable 2
// - on mode: 00 fccm, 01 auto pulse skipping, 10 ldo, 11 hysteretic; reset 01
// - on code: 0.85V plus 25mV per step, 66h..7Fh saturate at 3.4V
// - only upper five on-code bits loadable from otp or ice, 100mV steps
// - on code is upper 6:2 joined with lower 1:0, both reset zero
// - hw-control source: 00 none, 01 input 1, 10 input 2, 11 either
// - sleep code uses same mapping, saturating at 3.4V from 66h
`timescale 1ns/1ns
`default_nettype none
`include "buck3_consts.vh"
module buck3_hw_ctrl_on_config #(
  parameter ADDR_WIDTH = 16,
  parameter SLOT_WIDTH = 3
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADDR_WIDTH-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // configuration memory load
  input wire cfg_load,
  input wire [4:0] cfg_vcode_upper,
  // sequencer and pins
  input wire [SLOT_WIDTH-1:0] seq_timeslot,
  input wire seq_slot_strobe,
  input wire hwctl_in1,
  input wire hwctl_in2,
  input wire hwen_in1,
  input wire hwen_in2,
  // converter controls
  output reg conv_enable,
  output reg [1:0] conv_mode,
  output reg [6:0] conv_vcode,
  output reg [11:0] conv_millivolts,
  output reg overvoltage_guard_enable,
  output reg hwctl_active
);
  ////////////////////////////////////////////////////////////////////////
  // registers
  reg [1:0] hwctl_input_source_reg;
  reg hwctl_voltage_choice_reg;
  reg [1:0] hwctl_run_mode_reg;
  reg ovp_reg;
  reg [2:0] power_up_slot_reg;
  reg [1:0] normal_run_mode_reg;
  reg [4:0] vcode_upper_reg;
  reg [1:0] vcode_lower_reg;
  reg [6:0] sleep_voltage_code_reg;
  reg slot_enabled_reg;
  wire [6:0] normal_voltage_code;
  wire [3:0] pins_sync;
  wire req;
  wire wr;
  wire [15:0] wdata;
  wire [15:0] ctl2_rd;
  wire [15:0] oncfg_rd;
  wire [15:0] slp_rd;
  reg [31:0] rdata_next;
  reg hw_active_next;
  reg enable_next;
  reg [1:0] mode_next;
  reg [6:0] vcode_next;
  wire hwctl1_sync;
  wire hwctl2_sync;
  wire hwen1_sync;
  wire hwen2_sync;
  wire ctl2_hit;
  wire oncfg_hit;
  wire slp_hit;
  wire ctl2_wr_hi;
  wire ctl2_wr_lo;
  wire oncfg_wr_hi;
  wire oncfg_wr_lo;
  wire slp_wr_lo;
  reg slot_timed;
  reg slot_hwen1;
  reg slot_hwen2;
  reg hw_mode_disables;
  reg [1:0] hw_mode_applied;
  reg [1:0] on_mode_applied;

  assign normal_voltage_code = {vcode_upper_reg, vcode_lower_reg};
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign wdata = wb_dat_i[15:0];

  // pins come from outside, so synchronise before use
  buck3_sync2 #(.WIDTH(4)) pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({hwen_in2, hwen_in1, hwctl_in2, hwctl_in1}),
    .sync_out(pins_sync)
  );

  assign hwctl1_sync = pins_sync[0];
  assign hwctl2_sync = pins_sync[1];
  assign hwen1_sync = pins_sync[2];
  assign hwen2_sync = pins_sync[3];

  ////////////////////////////////////////////////////////////////////////
  // address and byte-lane decode; lanes 2 and 3 reach no field
  assign ctl2_hit = (wb_adr_i == `CONTROL_TWO_IDX);
  assign oncfg_hit = (wb_adr_i == `ON_CONFIG_IDX);
  assign slp_hit = (wb_adr_i == `SLEEP_CONTROL_IDX);
  assign ctl2_wr_hi = wr & ctl2_hit & wb_sel_i[1];
  assign ctl2_wr_lo = wr & ctl2_hit & wb_sel_i[0];
  assign oncfg_wr_hi = wr & oncfg_hit & wb_sel_i[1];
  assign oncfg_wr_lo = wr & oncfg_hit & wb_sel_i[0];
  assign slp_wr_lo = wr & slp_hit & wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////////
  // register writes; byte lanes 0 and 1 only, upper lanes unused
  always @(posedge clock) begin
    if (!rst_n) begin
      hwctl_input_source_reg <= `HWSRC_RST;
      hwctl_voltage_choice_reg <= `HWVSEL_RST;
      hwctl_run_mode_reg <= `HWMODE_RST;
      ovp_reg <= `OVP_RST;
      power_up_slot_reg <= `SLOT_RST;
      normal_run_mode_reg <= `ONMODE_RST;
      vcode_upper_reg <= `VUP_RST;
      vcode_lower_reg <= `VLO_RST;
      sleep_voltage_code_reg <= `SLPV_RST;
    end else begin
      if (ctl2_wr_hi) begin
        hwctl_input_source_reg <= wdata[`HWSRC_HI:`HWSRC_LO];
        hwctl_voltage_choice_reg <= wdata[`HWVSEL_BIT];
        hwctl_run_mode_reg <= wdata[`HWMODE_HI:`HWMODE_LO];
      end
      if (ctl2_wr_lo) begin
        ovp_reg <= wdata[`OVP_BIT];
      end
      if (oncfg_wr_hi) begin
        power_up_slot_reg <= wdata[`SLOT_HI:`SLOT_LO];
        normal_run_mode_reg <= wdata[`ONMODE_HI:`ONMODE_LO];
      end
      if (oncfg_wr_lo) begin
        vcode_upper_reg <= wdata[`VUP_HI:`VUP_LO];
        vcode_lower_reg <= wdata[`VLO_HI:`VLO_LO];
      end
      if (slp_wr_lo) begin
        sleep_voltage_code_reg <= wdata[`SLPV_HI:`SLPV_LO];
      end
      // a configuration load overrides a same-cycle bus write of the upper bits
      if (cfg_load) begin
        vcode_upper_reg <= cfg_vcode_upper;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux and ack; unmapped addresses read zero and still ack
  assign ctl2_rd = {3'h0, hwctl_input_source_reg, hwctl_voltage_choice_reg, hwctl_run_mode_reg, ovp_reg, 7'h00};
  assign oncfg_rd = {power_up_slot_reg, 3'h0, normal_run_mode_reg, 1'b0, vcode_upper_reg, vcode_lower_reg};
  assign slp_rd = {9'h000, sleep_voltage_code_reg};

  always @* begin
    case (wb_adr_i)
      `CONTROL_TWO_IDX: rdata_next = {16'h0000, ctl2_rd};
      `ON_CONFIG_IDX: rdata_next = {16'h0000, oncfg_rd};
      `SLEEP_CONTROL_IDX: rdata_next = {16'h0000, slp_rd};
      default: rdata_next = 32'h00000000;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rdata_next : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-up slot decode; the two hardware-enable codes bypass the sequencer
  always @* begin
    slot_timed = 1'b0;
    slot_hwen1 = 1'b0;
    slot_hwen2 = 1'b0;
    case (power_up_slot_reg)
      `SLOT_NEVER: begin
        slot_timed = 1'b0;
      end
      `SLOT_HWEN1: begin
        slot_hwen1 = 1'b1;
      end
      `SLOT_HWEN2: begin
        slot_hwen2 = 1'b1;
      end
      default: begin
        slot_timed = 1'b1;
      end
    endcase
  end

  // timed enable latches once its timeslot strobes; only reset or slot 000 clears it
  always @(posedge clock) begin
    if (!rst_n) begin
      slot_enabled_reg <= 1'b0;
    end else if (power_up_slot_reg == `SLOT_NEVER) begin
      slot_enabled_reg <= 1'b0;
    end else if (slot_timed && seq_slot_strobe &&
                 seq_timeslot == power_up_slot_reg[SLOT_WIDTH-1:0]) begin
      slot_enabled_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode decode; the off code shares its value with auto, so it is flagged apart
  always @* begin
    hw_mode_disables = 1'b0;
    case (hwctl_run_mode_reg)
      `MODE_FCCM: hw_mode_applied = `MODE_FCCM;
      `MODE_OFF: begin
        hw_mode_applied = `MODE_OFF;
        hw_mode_disables = 1'b1;
      end
      `MODE_LDO: hw_mode_applied = `MODE_LDO;
      `MODE_HYST: hw_mode_applied = `MODE_HYST;
      default: hw_mode_applied = `HWMODE_RST;
    endcase
    case (normal_run_mode_reg)
      `MODE_FCCM: on_mode_applied = `MODE_FCCM;
      `MODE_AUTO: on_mode_applied = `MODE_AUTO;
      `MODE_LDO: on_mode_applied = `MODE_LDO;
      `MODE_HYST: on_mode_applied = `MODE_HYST;
      default: on_mode_applied = `ONMODE_RST;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // active settings selection
  always @* begin
    case (hwctl_input_source_reg)
      `SRC_NONE: hw_active_next = 1'b0;
      `SRC_IN1: hw_active_next = hwctl1_sync;
      `SRC_IN2: hw_active_next = hwctl2_sync;
      `SRC_EITHER: hw_active_next = hwctl1_sync | hwctl2_sync;
      default: hw_active_next = 1'b0;
    endcase
    if (slot_hwen1) begin
      enable_next = hwen1_sync;
    end else if (slot_hwen2) begin
      enable_next = hwen2_sync;
    end else begin
      enable_next = slot_enabled_reg;
    end
    if (hw_active_next) begin
      // a disabled converter under hardware control ignores its enable source
      if (hw_mode_disables) begin
        enable_next = 1'b0;
      end
      mode_next = hw_mode_applied;
      vcode_next = hwctl_voltage_choice_reg ? sleep_voltage_code_reg : normal_voltage_code;
    end else begin
      mode_next = on_mode_applied;
      vcode_next = normal_voltage_code;
    end
  end

  // voltage in millivolts; saturate above the top step
  function [11:0] code_to_mv;
    input [6:0] code;
    begin
      if (code >= `VCODE_SAT) begin
        code_to_mv = `MV_SAT;
      end else begin
        code_to_mv = `MV_BASE + {5'h00, code} * `MV_STEP;
      end
    end
  endfunction

  always @(posedge clock) begin
    if (!rst_n) begin
      conv_enable <= 1'b0;
      conv_mode <= `ONMODE_RST;
      conv_vcode <= {`VUP_RST, `VLO_RST};
      conv_millivolts <= `MV_BASE;
      overvoltage_guard_enable <= `OVP_RST;
      hwctl_active <= 1'b0;
    end else begin
      conv_enable <= enable_next;
      conv_mode <= mode_next;
      conv_vcode <= vcode_next;
      conv_millivolts <= code_to_mv(vcode_next);
      overvoltage_guard_enable <= ovp_reg & enable_next;
      hwctl_active <= hw_active_next;
    end
  end
endmodule
`default_nettype wire

// ---- src/buck3_sync2.v ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module buck3_sync2 #(
  parameter WIDTH = 4
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // data
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;
  always @(posedge clock) begin
    if (!rst_n) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- tb/buck3_hw_ctrl_on_config_assertions.sv ----
// checker for the third buck converter configuration bank
`timescale 1ns/1ns
`default_nettype none
module buck3_cfg_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pins and converter
  input wire logic hwctl_in1,
  input wire logic hwctl_in2,
  input wire logic conv_enable,
  input wire logic [1:0] conv_mode,
  input wire logic [6:0] conv_vcode,
  input wire logic [11:0] conv_millivolts,
  input wire logic overvoltage_guard_enable,
  input wire logic hwctl_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  // millivolts are registered together with the code, so they match every cycle
  property p_mv; conv_millivolts ==
    (conv_vcode > 7'h65 ? 12'hd48 : 12'h352 + 12'h019 * {5'h0, conv_vcode}); endproperty
  a_mv: assert property (p_mv) else $error("millivolts wrong");
  property p_ovp; overvoltage_guard_enable |-> conv_enable; endproperty
  a_ovp: assert property (p_ovp) else $error("guard on while off");
  property p_rst; disable iff (1'b0) !rst_n |=> conv_mode == 2'h1 && conv_vcode == 7'h00
    && !conv_enable && !hwctl_active; endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_quiet; (!hwctl_in1 && !hwctl_in2) [*5] |-> !hwctl_active; endproperty
  a_quiet: assert property (p_quiet) else $error("control active, pins low");
endmodule
bind buck3_hw_ctrl_on_config buck3_cfg_checker chk (.clock, .rst_n, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .hwctl_in1, .hwctl_in2, .conv_enable, .conv_mode, .conv_vcode,
  .conv_millivolts, .overvoltage_guard_enable, .hwctl_active);
`default_nettype wire

// ---- tb/buck3_hw_ctrl_on_config_bench.sv ----
// bench for the third buck converter configuration bank
`timescale 1ns/1ns
`default_nettype none
module buck3_hw_ctrl_on_config_bench;
  logic clock = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ld = 1'b0, strb = 1'b0;
  logic [15:0] adr = 16'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [4:0] vup = 5'h00;
  logic [2:0] slot_no = 3'h0;
  logic [3:0] pins = 4'h0; // hwctl 1, hwctl 2, hwen 1, hwen 2
  logic [6:0] codes [5] = '{7'h00, 7'h01, 7'h65, 7'h66, 7'h7f};
  wire [31:0] dat_o;
  wire ack, en, ovp, act;
  wire [1:0] mode;
  wire [6:0] vcode;
  wire [11:0] mv;
  int err_total = 0, checked = 0, ticks = 0;
  always #2 clock = ~clock;
  buck3_hw_ctrl_on_config dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .cfg_load(ld), .cfg_vcode_upper(vup), .seq_timeslot(slot_no),
    .seq_slot_strobe(strb), .hwctl_in1(pins[0]), .hwctl_in2(pins[1]), .hwen_in1(pins[2]),
    .hwen_in2(pins[3]), .conv_enable(en), .conv_mode(mode), .conv_vcode(vcode),
    .conv_millivolts(mv), .overvoltage_guard_enable(ovp), .hwctl_active(act));
  ////////////////////////////////////////////////////////////
  function automatic logic [11:0] fmv(input logic [6:0] c);
    return (c > 7'h65) ? 12'hd48 : 12'h352 + 12'h019 * {5'h0, c};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic cycle; no fixed latency assumed, the timeout cuts a hang
  task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0, d};
    do @(posedge clock); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    bus(1'b0, a, 16'h0);
    chk(rdat, exp);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    ticks++;
    if (ticks == 4000) begin
      err_total++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    tick(4);
    rst_n <= 1'b1;
    tick(1);
    chk({en, mode, vcode, mv}, {1'b0, 2'h1, 7'h00, 12'h352});
    rd(16'h4061, 32'h0300);
    rd(16'h4062, 32'h0100);
    rd(16'h4063, 32'h0000);
    rd(16'h4070, 32'h0000);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 16'h4062, {6'h0, i[1:0], 1'b0, codes[i]});
      tick(4);
      chk({mode, vcode, mv}, {i[1:0], codes[i], fmv(codes[i])});
      rd(16'h4062, {22'h0, i[1:0], 1'b0, codes[i]});
    end
    vup <= 5'h15;
    ld <= 1'b1;
    tick(1);
    ld <= 1'b0;
    tick(4);
    chk(vcode, {5'h15, 2'h3});
    bus(1'b1, 16'h4062, 16'h6100);
    for (int s = 2; s < 4; s++) begin
      slot_no <= s[2:0];
      strb <= 1'b1;
      tick(1);
      strb <= 1'b0;
      tick(4);
      chk(en, s == 3);
    end
    bus(1'b1, 16'h4061, 16'h0380);
    tick(4);
    chk(ovp, 1'b1);
    bus(1'b1, 16'h4062, 16'h0100);
    tick(4);
    chk({en, ovp}, 2'h0);
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, 16'h4062, j ? 16'he144 : 16'hc144);
      pins <= j ? 4'h8 : 4'h4;
      tick(6);
      chk(en, 1'b1);
    end
    bus(1'b1, 16'h4061, 16'h0900);
    pins <= 4'h9;
    tick(6);
    chk({act, en, mode, vcode}, {1'b1, 1'b0, 2'h1, 7'h44});
    pins <= 4'h8;
    tick(6);
    chk({act, en}, 2'h1);
    bus(1'b1, 16'h4063, 16'h0020);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 16'h4061, {3'h0, s[1:0], 1'b1, 2'h0, 8'h00});
      pins <= (s == 2) ? 4'h2 : 4'h1;
      tick(6);
      chk({act, mode, vcode, mv}, (s != 0) ? {1'b1, 2'h0, 7'h20, fmv(7'h20)}
        : {1'b0, 2'h1, 7'h44, fmv(7'h44)});
      pins <= 4'h0;
      tick(6);
      chk({act, mode, vcode}, {1'b0, 2'h1, 7'h44});
    end
    complete_run();
  end
endmodule
`default_nettype wire
